// ### logic/dgc_config.sv
// general configuration register bank with output, filter and gating logic
// Functional notes
// - Without override the effective output enable is 1; the drive bit counts only under override.
// - The override bit chooses register values over defaults for drive and unlocked state.
// - With the oscillator bit set and no lock, the internal oscillator clock drives the pixel clock.
// - The unlocked state select applies while lock is low and reads as 1 without override.
// - The check generation bit enables back-channel CRC and resets to 1.
// - The pull bit pulls undriven inputs down when 1, up when 0, and resets to 1.
// - With the filter on, sync and active pulses shorter than two pixel clocks are dropped.
// - Horizontal sync needs four clocks in dual-link mode, two in single-link mode.
// - Pass-through forwards local transfers to the serializer only when set and decode matches.
// - Auto-acknowledge acks local writes whatever the forward lock state.
// - Gating masks pixel data by active, always so with a protected serializer.
// - The logic-only soft reset clears logic but not registers and clears itself.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

// sync/active pulse filter: output follows input only after it has held n clocks
module dgc_pulse_filter (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       softRst,
    input  wire logic       enable,
    input  wire logic [2:0] minLen,
    input  wire logic       din,
    output logic            dout
);
    typedef struct packed {
        logic       stable;
        logic [2:0] cnt;
    } dgc_filt_t;
    dgc_filt_t st_q;
    dgc_filt_t st_d;

    // count how long the input has differed from the filtered level
    always_comb begin
        st_d = st_q;
        // idle count is zero so a one clock pulse can never reach a minLen of 2 or more
        if (din == st_q.stable) begin
            st_d.cnt = 3'h0;
        end else if (st_q.cnt + 3'h1 >= minLen) begin
            st_d.stable = din;
            st_d.cnt    = 3'h0;
        end else begin
            st_d.cnt = st_q.cnt + 3'h1;
        end
        if (softRst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // bypass keeps the raw signal; filtering costs minLen cycles of delay
    assign dout = enable ? st_q.stable : din;
endmodule

module dgc_config (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link and video side
    input  wire logic        linkLock,
    input  wire logic        dualLink,
    input  wire logic        partnerProtected,
    input  wire logic        oscClock,
    input  wire logic        recoveredClock,
    input  wire logic        activeIn,
    input  wire logic        hSyncIn,
    input  wire logic        vSyncIn,
    input  wire logic [23:0] pixelIn,
    input  wire logic        i2cDecodeMatch,
    input  wire logic        i2cIsWrite,
    output logic             activeOut,
    output logic             hSyncOut,
    output logic             vSyncOut,
    output logic [23:0]      pixelOut,
    output logic             pixelClockOut,
    output logic             outputEnable,
    output logic             unlockedStateSelect,
    output logic             fallbackOscClockOut,
    output logic             backChannelCheckGen,
    output logic             undrivenInputPullDown,
    output logic             i2cForward,
    output logic             i2cAutoAck,
    output logic             logicOnlySoftReset
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  outCtl;
        logic [7:0]  misc;
        logic        softRst;
        logic        awHeld;
        logic [9:0]  awIdx;
        logic        wHeld;
        logic [7:0]  wData;
        logic        wLane0;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [23:0] pixel;
    } dgc_state_t;
    dgc_state_t st_q;
    dgc_state_t st_d;

    logic       filtActive;
    logic       filtHSync;
    logic       filtVSync;
    logic       filterOn;
    logic [2:0] hSyncLen;
    logic       gateOn;
    logic [9:0] arIdx;
    logic       wrFire;
    logic       rdFire;

    assign arIdx  = s_axi_araddr[11:2];
    assign wrFire = st_q.awHeld && st_q.wHeld && !st_q.bValid;
    assign rdFire = s_axi_arvalid && s_axi_arready;

    // ----------------------------------------------------------------
    // effective controls
    // ----------------------------------------------------------------
    assign filterOn = st_q.misc[dgc_pkg::FILTER_BIT];
    assign hSyncLen = dualLink ? dgc_pkg::FILT_LONG : dgc_pkg::FILT_SHORT;
    // protected partner forces gating, otherwise the register decides
    assign gateOn   = partnerProtected || st_q.misc[dgc_pkg::GATE_BIT];

    // ----------------------------------------------------------------
    // register and bus next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.softRst = 1'b0;                                   // self clearing
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.awHeld = 1'b1;
            st_d.awIdx  = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.wHeld  = 1'b1;
            st_d.wData  = s_axi_wdata[7:0];
            st_d.wLane0 = s_axi_wstrb[0];
        end
        if (wrFire) begin
            st_d.awHeld = 1'b0;
            st_d.wHeld  = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp  = dgc_pkg::RESP_OKAY;
            // full index decode: an alias in the upper index bits must not write
            unique case (st_q.awIdx)
                {2'h0, dgc_pkg::REG_OUTCTL_IDX}: begin
                    if (st_q.wLane0) begin
                        st_d.outCtl = st_q.wData & dgc_pkg::OUTCTL_MASK;
                    end
                end
                {2'h0, dgc_pkg::REG_MISC_IDX}: begin
                    if (st_q.wLane0) begin
                        st_d.misc = st_q.wData & dgc_pkg::MISC_MASK;
                    end
                end
                {2'h0, dgc_pkg::REG_RESET_IDX}: begin
                    if (st_q.wLane0) begin
                        st_d.softRst = st_q.wData[dgc_pkg::SOFT_RESET_BIT];
                    end
                end
                {2'h0, dgc_pkg::REG_STATUS_IDX}: begin
                    st_d.bResp = dgc_pkg::RESP_OKAY;                // read-only, write ignored
                end
                default: begin
                    st_d.bResp = dgc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_q.bValid && s_axi_bready) begin
            st_d.bValid = 1'b0;
        end
        if (st_q.rValid && s_axi_rready) begin
            st_d.rValid = 1'b0;
        end
        if (rdFire) begin
            st_d.rValid = 1'b1;
            st_d.rResp  = dgc_pkg::RESP_OKAY;
            st_d.rData  = 32'h0;
            if (arIdx == {2'h0, dgc_pkg::REG_OUTCTL_IDX}) begin
                st_d.rData[7:0] = st_q.outCtl;
            end else if (arIdx == {2'h0, dgc_pkg::REG_MISC_IDX}) begin
                st_d.rData[7:0] = st_q.misc;
            end else if (arIdx == {2'h0, dgc_pkg::REG_RESET_IDX}) begin
                st_d.rData[7:0] = 8'h00;                              // self clearing reads 0
            end else if (arIdx == {2'h0, dgc_pkg::REG_STATUS_IDX}) begin
                st_d.rData[3:0] = {partnerProtected, dualLink, gateOn, linkLock};
            end else begin
                st_d.rResp = dgc_pkg::RESP_SLVERR;
            end
        end
        // pixel gate: colour data held at zero outside the active window
        st_d.pixel = (gateOn && !filtActive) ? 24'h0 : pixelIn;
        if (st_q.softRst) begin
            st_d.pixel = 24'h0;                                 // logic only
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q        <= '0;
            st_q.outCtl <= dgc_pkg::OUTCTL_RESET;
            st_q.misc   <= dgc_pkg::MISC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // bus handshakes: one outstanding write and one read at a time
    // ----------------------------------------------------------------
    assign s_axi_awready = !st_q.awHeld && !st_q.bValid;
    assign s_axi_wready  = !st_q.wHeld && !st_q.bValid;
    assign s_axi_arready = !st_q.rValid;
    assign s_axi_bvalid  = st_q.bValid;
    assign s_axi_bresp   = st_q.bResp;
    assign s_axi_rvalid  = st_q.rValid;
    assign s_axi_rdata   = st_q.rData;
    assign s_axi_rresp   = st_q.rResp;

    // ----------------------------------------------------------------
    // sync and active filters
    // ----------------------------------------------------------------
    dgc_pulse_filter uActive (
        .clock   (clock),
        .rst_b   (rst_b),
        .softRst (st_q.softRst),
        .enable  (filterOn),
        .minLen  (dgc_pkg::FILT_SHORT),
        .din     (activeIn),
        .dout    (filtActive)
    );
    dgc_pulse_filter uHSync (
        .clock   (clock),
        .rst_b   (rst_b),
        .softRst (st_q.softRst),
        .enable  (filterOn),
        .minLen  (hSyncLen),
        .din     (hSyncIn),
        .dout    (filtHSync)
    );
    dgc_pulse_filter uVSync (
        .clock   (clock),
        .rst_b   (rst_b),
        .softRst (st_q.softRst),
        .enable  (filterOn),
        .minLen  (dgc_pkg::FILT_SHORT),
        .din     (vSyncIn),
        .dout    (filtVSync)
    );

    assign activeOut = filtActive;
    assign hSyncOut  = filtHSync;
    assign vSyncOut  = filtVSync;
    assign pixelOut  = st_q.pixel;

    // ----------------------------------------------------------------
    // output controls
    // ----------------------------------------------------------------
    // defaults stand until override is set
    assign outputEnable = st_q.outCtl[dgc_pkg::OVERRIDE_BIT] ?
        st_q.outCtl[dgc_pkg::OUT_DRIVE_BIT] : 1'b1;
    assign unlockedStateSelect = st_q.outCtl[dgc_pkg::OVERRIDE_BIT] ?
        st_q.outCtl[dgc_pkg::UNLOCK_SEL_BIT] : 1'b1;
    assign fallbackOscClockOut = st_q.outCtl[dgc_pkg::OSC_CLK_BIT] && !linkLock;
    // clock mux is combinational; a glitch on lock change is accepted here
    assign pixelClockOut = fallbackOscClockOut ? oscClock : recoveredClock;
    assign backChannelCheckGen   = st_q.misc[dgc_pkg::CHECK_GEN_BIT];
    assign undrivenInputPullDown = st_q.misc[dgc_pkg::PULL_DOWN_BIT];
    assign i2cForward = st_q.misc[dgc_pkg::PASS_BIT] && i2cDecodeMatch;
    assign i2cAutoAck = st_q.misc[dgc_pkg::AUTO_ACK_BIT] && i2cIsWrite;
    assign logicOnlySoftReset = st_q.softRst;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence wrMiscSeq;
        wrFire && st_q.awIdx == {2'h0, dgc_pkg::REG_MISC_IDX} && st_q.wLane0;
    endsequence

    default_enable_a: assert property (@(posedge clock) disable iff (!rst_b)
        !st_q.outCtl[dgc_pkg::OVERRIDE_BIT] |-> outputEnable)
        else $error("output enable not forced without override");
    override_use_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_q.outCtl[dgc_pkg::OVERRIDE_BIT] |->
        outputEnable == st_q.outCtl[7] && unlockedStateSelect == st_q.outCtl[4])
        else $error("override values not applied");
    osc_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
        (st_q.outCtl[5] && !linkLock) |-> pixelClockOut == oscClock)
        else $error("oscillator clock not on pixel clock");
    unlock_default_a: assert property (@(posedge clock) disable iff (!rst_b)
        !st_q.outCtl[6] |-> unlockedStateSelect)
        else $error("unlocked state default not 1");
    misc_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        wrMiscSeq |=> st_q.misc == ($past(st_q.wData) & 8'h7e)
        && backChannelCheckGen == st_q.misc[6])
        else $error("misc register write lost");
    short_pulse_a: assert property (@(posedge clock) disable iff (!rst_b || st_q.softRst)
        (filterOn && !dualLink && $stable(filterOn) && vSyncIn && !$past(vSyncIn)
        && !vSyncOut) ##1 !vSyncIn |=> !vSyncOut)
        else $error("one clock pulse passed the filter");
    forward_a: assert property (@(posedge clock) disable iff (!rst_b)
        i2cForward |-> st_q.misc[3] && i2cDecodeMatch)
        else $error("forward without enable");
    auto_ack_a: assert property (@(posedge clock) disable iff (!rst_b)
        (st_q.misc[2] && i2cIsWrite) |-> i2cAutoAck)
        else $error("auto acknowledge missing");
    pixel_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        (gateOn && !filtActive && !st_q.softRst) |=> pixelOut == 24'h0)
        else $error("pixel not gated");
    soft_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_q.softRst |=> !st_q.softRst && $stable(st_q.misc))
        else $error("soft reset did not clear");
    reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        (st_q.outCtl[3:0] == 4'h0) && !st_q.misc[7] && !st_q.misc[0])
        else $error("reserved bit set");
endmodule
`default_nettype wire

// ### pkg/dgc_pkg.sv
// constants for the deserializer general configuration register bank
package dgc_pkg;
    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET_IDX  = 8'h01;
    localparam logic [7:0] REG_OUTCTL_IDX = 8'h02;
    localparam logic [7:0] REG_MISC_IDX   = 8'h03;
    localparam logic [7:0] REG_STATUS_IDX = 8'h04;
    localparam int         ADDR_W         = 12;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OUT_DRIVE_BIT   = 7;
    localparam int OVERRIDE_BIT    = 6;
    localparam int OSC_CLK_BIT     = 5;
    localparam int UNLOCK_SEL_BIT  = 4;
    localparam int CHECK_GEN_BIT   = 6;
    localparam int PULL_DOWN_BIT   = 5;
    localparam int FILTER_BIT      = 4;
    localparam int PASS_BIT        = 3;
    localparam int AUTO_ACK_BIT    = 2;
    localparam int GATE_BIT        = 1;
    localparam int SOFT_RESET_BIT  = 0;
    // ----------------------------------------------------------------
    // reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] OUTCTL_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET   = 8'h70;
    localparam logic [7:0] OUTCTL_MASK  = 8'hf0;
    localparam logic [7:0] MISC_MASK    = 8'h7e;
    // ----------------------------------------------------------------
    // glitch filter lengths in pixel clocks and bus response codes
    // ----------------------------------------------------------------
    localparam logic [2:0] FILT_SHORT   = 3'h2;
    localparam logic [2:0] FILT_LONG    = 3'h4;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// ### sim/dgc_serializer_model.sv
// behavioural model of the paired serializer: link status and video stream
`timescale 1ns/1ns
`default_nettype none
module dgc_serializer_model (
    input  wire logic   clock,
    output logic        linkLock,
    output logic        dualLink,
    output logic        partnerProtected,
    output logic        recoveredClock,
    output logic        activeIn,
    output logic        hSyncIn,
    output logic        vSyncIn,
    output logic [23:0] pixelIn
);
    // start out of lock with the timing lines idle
    initial begin
        {linkLock, dualLink, partnerProtected, recoveredClock} = '0;
        {activeIn, hSyncIn, vSyncIn} = '0;
        pixelIn = '0;
    end
    // toggles on every rising edge so the clock mux shows which source it picked
    always @(posedge clock) recoveredClock <= ~recoveredClock;
    // link state changes land just after an edge
    task automatic setLink(input logic lk, input logic dl, input logic pr);
        @(posedge clock);
        linkLock <= lk;
        dualLink <= dl;
        partnerProtected <= pr;
    endtask
    // steady active level and pixel word
    task automatic setVideo(input logic act, input logic [23:0] pix);
        @(posedge clock);
        activeIn <= act;
        pixelIn <= pix;
    endtask
    // one high pulse on the chosen timing line, len clocks wide
    task automatic pulse(input int sel, input int len);
        @(posedge clock);
        case (sel)
            0: activeIn <= 1'b1;
            1: hSyncIn <= 1'b1;
            default: vSyncIn <= 1'b1;
        endcase
        repeat (len) @(posedge clock);
        {activeIn, hSyncIn, vSyncIn} <= '0;
    endtask
endmodule
`default_nettype wire

// ### sim/test_deserializer_general_config.sv
// self-checking bench for the general configuration register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errTotal++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module test_deserializer_general_config;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clock, rst_b, awValid, wValid, bReady, arValid, rReady;
    logic        oscClock, decMatch, isWrite, awReady, wReady, bValid, arReady, rValid;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [1:0]  bResp, rResp;
    logic        lock, dual, prot, recClk, actIn, hsIn, vsIn;
    logic [23:0] pixIn, pixOut;
    logic        actOut, hsOut, vsOut, pclk, oe, uss, fbo, bcc, pdn, fwd, ack, srst;
    int          errTotal = 0, numChecks = 0, cyc = 0, seed = 70045, softCnt = 0;
    // pulse filter cases: line, dual link, width, expected to pass
    int          fTab [8][4] = '{'{0,0,1,0}, '{0,0,2,1}, '{1,0,1,0}, '{1,0,2,1},
                                 '{1,1,3,0}, '{1,1,4,1}, '{2,0,1,0}, '{2,0,2,1}};

    initial clock = 1'b0;
    always #50 clock = ~clock;
    // slow stand-in for the internal oscillator, changed on the edge like any input
    always @(posedge clock) if (cyc % 3 == 0) oscClock <= ~oscClock;
    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errTotal++;
            finishTest();
        end
    end
    // counts soft reset pulses, sampled mid-cycle where they are settled
    always @(negedge clock) softCnt += int'(srst);

    dgc_config i_dgc_config (.clock(clock), .rst_b(rst_b),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .linkLock(lock), .dualLink(dual),
        .partnerProtected(prot), .oscClock(oscClock), .recoveredClock(recClk),
        .activeIn(actIn), .hSyncIn(hsIn), .vSyncIn(vsIn), .pixelIn(pixIn),
        .i2cDecodeMatch(decMatch), .i2cIsWrite(isWrite), .activeOut(actOut),
        .hSyncOut(hsOut), .vSyncOut(vsOut), .pixelOut(pixOut), .pixelClockOut(pclk),
        .outputEnable(oe), .unlockedStateSelect(uss), .fallbackOscClockOut(fbo),
        .backChannelCheckGen(bcc), .undrivenInputPullDown(pdn), .i2cForward(fwd),
        .i2cAutoAck(ack), .logicOnlySoftReset(srst));

    dgc_serializer_model i_dgc_serializer_model (.clock(clock), .linkLock(lock),
        .dualLink(dual), .partnerProtected(prot), .recoveredClock(recClk),
        .activeIn(actIn), .hSyncIn(hsIn), .vSyncIn(vsIn), .pixelIn(pixIn));

    // ----------------------------------------------------------------
    // bus and check tasks, entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic axiWrite(input logic [11:0] a, input logic [7:0] d,
                            output logic [1:0] r);
        logic [31:0] v;
        logic        ta, tw, tb;
        v = $random(seed);
        v[7:0] = d;
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        forever begin
            @(negedge clock);
            ta = awValid & awReady;
            tw = wValid & wReady;
            tb = bValid;
            r = bResp;
            @(posedge clock);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
            if (tb) begin
                bReady <= 1'b0;
                break;
            end
        end
        // one edge between calls so bReady is never lowered and raised in one step
        @(posedge clock);
    endtask

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                           output logic [1:0] r);
        logic ta, tr;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        forever begin
            @(negedge clock);
            ta = arValid & arReady;
            tr = rValid;
            d = rData;
            r = rResp;
            @(posedge clock);
            if (ta) arValid <= 1'b0;
            if (tr) begin
                rReady <= 1'b0;
                break;
            end
        end
        // one edge between calls so rReady is never lowered and raised in one step
        @(posedge clock);
    endtask

    // read back both registers and compare every static output with them
    task automatic checkAll(input logic [7:0] r0, input logic [7:0] r1);
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(12'h008, d, r);
        `CHK(d, {24'h0, r0 & dgc_pkg::OUTCTL_MASK})
        `CHK(r, dgc_pkg::RESP_OKAY)
        axiRead(12'h00c, d, r);
        `CHK(d, {24'h0, r1 & dgc_pkg::MISC_MASK})
        // status word: lock, effective gate, dual link, protected partner
        axiRead(12'h010, d, r);
        `CHK(d, {28'h0, prot, dual, prot | r1[1], lock})
        @(negedge clock);
        `CHK(oe, r0[6] ? r0[7] : 1'b1)
        `CHK(uss, r0[6] ? r0[4] : 1'b1)
        `CHK(fbo, r0[5] & !lock)
        `CHK(pclk, (r0[5] & !lock) ? oscClock : recClk)
        `CHK(bcc, r1[6])
        `CHK(pdn, r1[5])
        `CHK(fwd, r1[3] & decMatch)
        `CHK(ack, r1[2] & isWrite)
        @(posedge clock);
    endtask

    // one pulse on a timing line; did any of it reach the output
    task automatic pulseChk(input int sel, input int len, input logic exp);
        logic seen;
        seen = 1'b0;
        fork
            i_dgc_serializer_model.pulse(sel, len);
            repeat (12) begin
                @(negedge clock);
                seen |= (sel == 0) ? actOut : (sel == 1) ? hsOut : vsOut;
            end
        join
        `CHK(seen, exp)
        @(posedge clock);
    endtask

    task automatic finishTest();
        if (errTotal == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin : mainSeq
        logic [7:0]  r0, r1;
        logic [31:0] d;
        logic [23:0] px;
        logic [1:0]  r;
        int          c;
        {rst_b, awValid, wValid, bReady, arValid, rReady} = '0;
        {oscClock, decMatch, isWrite} = '0;
        {awAddr, arAddr, wData} = '0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        checkAll(8'h00, 8'h70);
        // random register contents, lock state and transfer decode
        for (int i = 0; i < 16; i++) begin
            r0 = $random(seed);
            r1 = $random(seed);
            i_dgc_serializer_model.setLink(1'($random(seed)), 1'b0, 1'b0);
            decMatch <= 1'($random(seed));
            isWrite <= 1'($random(seed));
            axiWrite(12'h008, r0, r);
            `CHK(r, dgc_pkg::RESP_OKAY)
            if (r0[7]) begin
                c = softCnt;
                axiWrite(12'h004, 8'h01, r);
                repeat (3) @(posedge clock);
                `CHK(softCnt, c + 1)
            end
            axiWrite(12'h00c, r1, r);
            checkAll(r0, r1);
        end
        // unmapped place: refused and without effect
        axiWrite(12'h020, 8'hff, r);
        `CHK(r, dgc_pkg::RESP_SLVERR)
        axiRead(12'h020, d, r);
        `CHK(r, dgc_pkg::RESP_SLVERR)
        checkAll(r0, r1);
        // pulse filter on, short and just-long-enough pulses
        axiWrite(12'h00c, 8'h70, r);
        for (int k = 0; k < 8; k++) begin
            i_dgc_serializer_model.setLink(1'b1, fTab[k][1][0], 1'b0);
            pulseChk(fTab[k][0], fTab[k][2], fTab[k][3][0]);
        end
        // filter off; gate bit, protected partner and active level in all combinations
        for (int g = 0; g < 8; g++) begin
            px = 24'($random(seed));
            i_dgc_serializer_model.setLink(1'b1, 1'b0, g[1]);
            axiWrite(12'h00c, {6'h18, g[0], 1'b0}, r);
            i_dgc_serializer_model.setVideo(g[2], px);
            repeat (3) @(negedge clock);
            `CHK(pixOut, ((g[0] | g[1]) & !g[2]) ? 24'h0 : px)
            @(posedge clock);
        end
        i_dgc_serializer_model.setVideo(1'b0, 24'h0);
        pulseChk(0, 1, 1'b1);
        finishTest();
    end
endmodule
`default_nettype wire
